// ---- core/dbg_hold_pkg.sv ----
// constants for the debug hold and scan chain block
package dbg_hold_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] ID_ADDR = 12'h000;
	localparam logic [11:0] CTL_ADDR = 12'h004;
	localparam logic [11:0] PINCFG_ADDR = 12'h008;
	localparam logic [11:0] STATUS_ADDR = 12'h00C;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// identity values, arbitrary neutral values
	localparam logic [31:0] APB_ID_VALUE = 32'h1234_5001;
	localparam logic [31:0] BSCAN_ID_VALUE = 32'h1234_5003;
	localparam logic [31:0] CORE_ID_VALUE = 32'h1234_5005;
	// ------------------------------------------------------------
	// hold control word layout
	// ------------------------------------------------------------
	localparam int SLEEP_BIT = 0;
	localparam int DSLEEP_BIT = 1;
	localparam int STANDBY_BIT = 2;
	localparam int FWDG_BIT = 8;
	localparam int WWDG_BIT = 9;
	localparam int TIMER_LO_BIT = 10;
	localparam int CAN0_BIT = 14;
	localparam int SMB0_BIT = 15;
	localparam int SMB1_BIT = 16;
	localparam int TIMER_HI_BIT = 18;
	localparam int CAN1_BIT = 21;
	localparam logic [31:0] CTL_WMASK = 32'h003D_FF07;
	localparam logic [31:0] CTL_RESET = 32'h0000_0000;
	// ------------------------------------------------------------
	// debug pin configuration
	// ------------------------------------------------------------
	localparam logic [1:0] PIN_FULL = 2'h0;
	localparam logic [1:0] PIN_NO_RESET = 2'h1;
	localparam logic [1:0] PIN_RELEASED = 2'h2;
	localparam logic [1:0] PINCFG_RESET = PIN_FULL;
	// ------------------------------------------------------------
	// scan chain
	// ------------------------------------------------------------
	localparam int IR_LEN = 5;
	localparam int DR_LEN = 32;
	localparam logic [4:0] IR_IDCODE = 5'h01;
	localparam logic [4:0] IR_BYPASS = 5'h1F;
	localparam logic [4:0] IR_CAPTURE = 5'h01;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR,
		TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR,
		TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR,
		TAP_UPD_IR
	} tap_state_type;
endpackage

// ---- core/debug_hold_jtag_chain.sv ----
// debug hold unit, debug pin control and two chained scan taps
//
// Functional notes
// - five scan wires; probe drives clock, mode, data in, reset.
// - pin configuration resets to full five-wire mode.
// - reset pin released means internal tap reset held high.
// - all five debug pins may be handed to general use.
// - core debug tap and boundary tap chained between data pins.
// - each tap has a 5-bit instruction register, ten bits total.
// - boundary tap returns a fixed 32-bit identification code.
// - debug registers reset only by power-on reset.
// - system reset leaves debug registers untouched.
// - scan reset clears the tap state machine and the data out enable.
// - standby hold sources bus and system clock from rc oscillator.
// - leaving standby raises a system reset request.
// - deep-sleep hold sources clocks from rc oscillator.
// - sleep hold keeps the bus clock to the core running.
// - peripheral hold acts only while core halted and bit set.
// - timer hold stops and keeps the counter while halted.
// - bus controller hold freezes smbus timeout while halted.
// - watchdog hold stops the counter clock while halted.
// - can hold stops reception while halted.
// - hold controls clear to zero on power reset only.
// - sleep, deep-sleep, standby holds sit at bits 0, 1, 2.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
module debug_hold_jtag_chain
	import dbg_hold_pkg::*;
(
	// clock and power-on reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// scan pins
	input wire logic scan_clock_pin,
	input wire logic scan_mode_select_pin,
	input wire logic scan_data_in_pin,
	input wire logic scan_reset_n_pin,
	output logic scan_data_out_pin,
	output logic scan_data_out_oe,
	// pin ownership, one bit per debug pin
	output logic [4:0] gpio_release,
	// core and power state
	input wire logic core_halted,
	input wire logic sleep_mode,
	input wire logic deepsleep_mode,
	input wire logic standby_mode,
	// clock steering and reset request
	output logic ahb_clk_keep,
	output logic sys_clk_from_rc,
	output logic sys_reset_req,
	// peripheral freezes
	output logic [6:0] timer_freeze,
	output logic [1:0] smbus_timeout_freeze,
	output logic window_watchdog_freeze,
	output logic free_watchdog_freeze,
	output logic [1:0] can_rx_freeze
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// value captured into a tap data register for its instruction
	function automatic logic [31:0] dr_capture(input logic [4:0] ir,
		input logic [31:0] id);
		dr_capture = (ir == IR_IDCODE) ? id : ZERO_WORD;
	endfunction

	// one data register stage; bypass shortens it to one bit
	function automatic logic [31:0] dr_shift(input logic [4:0] ir,
		input logic [31:0] dr, input logic din);
		if (ir == IR_IDCODE) begin
			dr_shift = {din, dr[31:1]};
		end else begin
			dr_shift = {dr[31:1], din};
		end
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0] ctl_r;
	logic [1:0] pincfg_r;
	logic [2:0] tck_sync_r, tms_sync_r, tdi_sync_r, trst_sync_r;
	logic tck_level_r;
	tap_state_type tap_r, tap_nxt;
	logic [9:0] ir_shift_r;
	logic [4:0] core_ir_r, bscan_ir_r;
	logic [31:0] core_dr_r, bscan_dr_r;
	logic standby_d_r;
	logic [31:0] rd_word;
	logic addr_ok, wr_take, tck_rise, tck_fall, tap_clear, trst_level;

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------

	// one wait state: pready rises on the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	// read decode, unmapped addresses read zero with an error
	always_comb begin
		addr_ok = 1'b1;
		rd_word = ZERO_WORD;
		case (paddr)
			ID_ADDR: begin
				rd_word = APB_ID_VALUE;
			end
			CTL_ADDR: begin
				rd_word = ctl_r;
			end
			PINCFG_ADDR: begin
				rd_word = {30'h0000_0000, pincfg_r};
			end
			STATUS_ADDR: begin
				rd_word = {23'h00_0000, trst_level, standby_mode,
					deepsleep_mode, sleep_mode, core_halted,
					4'(tap_r)};
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// read data and error are captured with the ready pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= ZERO_WORD;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			prdata <= pwrite ? ZERO_WORD : rd_word;
			pslverr <= !addr_ok;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// writes land on the edge where pready is sampled high
	assign wr_take = psel && penable && pready && pwrite;

	// only presetn clears; no system reset reaches here
	// system reset has no path into these registers
	// hold controls clear only on power reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= CTL_RESET;
		end else if (wr_take && paddr == CTL_ADDR) begin
			// reserved bits stay zero via the mask
			ctl_r <= pwdata & CTL_WMASK;
		end
	end

	// five-wire mode is the reset choice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pincfg_r <= PINCFG_RESET;
		end else if (wr_take && paddr == PINCFG_ADDR) begin
			pincfg_r <= pwdata[1:0];
		end
	end

	// ------------------------------------------------------------
	// debug pin ownership
	// ------------------------------------------------------------

	// released mode gives away all five pins
	// bit 4 is the reset pin, bits 3:0 clock, mode, data in, out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpio_release <= 5'h00;
		end else begin
			case (pincfg_r)
				PIN_NO_RESET: begin
					gpio_release <= 5'h10;
				end
				PIN_RELEASED: begin
					gpio_release <= 5'h1F;
				end
				default: begin
					gpio_release <= 5'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// scan pin synchronisers
	// ------------------------------------------------------------

	// probe-driven pins pass three flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_sync_r <= 3'h0;
			tms_sync_r <= 3'h7;
			tdi_sync_r <= 3'h0;
			trst_sync_r <= 3'h0;
		end else begin
			tck_sync_r <= {tck_sync_r[1:0], scan_clock_pin};
			tms_sync_r <= {tms_sync_r[1:0], scan_mode_select_pin};
			tdi_sync_r <= {tdi_sync_r[1:0], scan_data_in_pin};
			trst_sync_r <= {trst_sync_r[1:0], scan_reset_n_pin};
		end
	end

	// a clock change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_level_r <= 1'b0;
		end else if (tck_sync_r[1] == tck_sync_r[2]) begin
			tck_level_r <= tck_sync_r[2];
		end
	end

	assign tck_rise = (tck_sync_r[1] == tck_sync_r[2]) &&
		tck_sync_r[2] && !tck_level_r;
	assign tck_fall = (tck_sync_r[1] == tck_sync_r[2]) &&
		!tck_sync_r[2] && tck_level_r;

	// without the reset pin the internal reset stays high
	assign trst_level = (pincfg_r == PIN_FULL) ? trst_sync_r[2] : 1'b1;
	// released pins hold the taps in reset, ignoring pin noise
	assign tap_clear = !trst_level || pincfg_r == PIN_RELEASED;

	// ------------------------------------------------------------
	// tap controller, shared by both taps on the common mode pin
	// ------------------------------------------------------------

	// standard sixteen-state walk on the mode select level
	always_comb begin
		case (tap_r)
			TAP_RESET: tap_nxt = tms_sync_r[2] ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_nxt = tms_sync_r[2] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_nxt = tms_sync_r[2] ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_nxt = tms_sync_r[2] ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: tap_nxt = tms_sync_r[2] ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_nxt = tms_sync_r[2] ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_nxt = tms_sync_r[2] ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_nxt = tms_sync_r[2] ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_nxt = tms_sync_r[2] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_nxt = tms_sync_r[2] ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_nxt = tms_sync_r[2] ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: tap_nxt = tms_sync_r[2] ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_nxt = tms_sync_r[2] ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_nxt = tms_sync_r[2] ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_nxt = tms_sync_r[2] ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_nxt = tms_sync_r[2] ? TAP_SEL_DR : TAP_IDLE;
			default: tap_nxt = TAP_RESET;
		endcase
	end

	// scan reset clears the state machine; the data out enable drops with it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_r <= TAP_RESET;
		end else if (tap_clear) begin
			tap_r <= TAP_RESET;
		end else if (tck_rise) begin
			tap_r <= tap_nxt;
		end
	end

	// ------------------------------------------------------------
	// instruction registers
	// ------------------------------------------------------------

	// ten-bit chain, core five near data in, boundary five out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir_shift_r <= 10'h000;
		end else if (tck_rise && tap_r == TAP_CAP_IR) begin
			ir_shift_r <= {IR_CAPTURE, IR_CAPTURE};
		end else if (tck_rise && tap_r == TAP_SH_IR) begin
			ir_shift_r <= {tdi_sync_r[2], ir_shift_r[9:1]};
		end
	end

	// test-logic-reset state selects the identification code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_ir_r <= IR_IDCODE;
			bscan_ir_r <= IR_IDCODE;
		end else if (tap_r == TAP_RESET) begin
			core_ir_r <= IR_IDCODE;
			bscan_ir_r <= IR_IDCODE;
		end else if (tck_rise && tap_r == TAP_UPD_IR) begin
			core_ir_r <= ir_shift_r[9:5];
			bscan_ir_r <= ir_shift_r[4:0];
		end
	end

	// ------------------------------------------------------------
	// data registers
	// ------------------------------------------------------------

	// data in feeds the core tap, whose bit 0 feeds boundary
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_dr_r <= ZERO_WORD;
		end else if (tck_rise && tap_r == TAP_CAP_DR) begin
			core_dr_r <= dr_capture(core_ir_r, CORE_ID_VALUE);
		end else if (tck_rise && tap_r == TAP_SH_DR) begin
			core_dr_r <= dr_shift(core_ir_r, core_dr_r, tdi_sync_r[2]);
		end
	end

	// boundary tap captures its fixed identification code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bscan_dr_r <= ZERO_WORD;
		end else if (tck_rise && tap_r == TAP_CAP_DR) begin
			bscan_dr_r <= dr_capture(bscan_ir_r, BSCAN_ID_VALUE);
		end else if (tck_rise && tap_r == TAP_SH_DR) begin
			bscan_dr_r <= dr_shift(bscan_ir_r, bscan_dr_r, core_dr_r[0]);
		end
	end

	// ------------------------------------------------------------
	// data out pin
	// ------------------------------------------------------------

	// device drives data out, updated on the falling clock
	// driven only in shift states, so the pin idles undriven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_data_out_pin <= 1'b0;
			scan_data_out_oe <= 1'b0;
		end else if (tap_clear) begin
			scan_data_out_oe <= 1'b0;
		end else if (tck_fall) begin
			scan_data_out_pin <= (tap_r == TAP_SH_IR) ?
				ir_shift_r[0] : bscan_dr_r[0];
			scan_data_out_oe <= tap_r == TAP_SH_IR || tap_r == TAP_SH_DR;
		end
	end

	// ------------------------------------------------------------
	// low-power clock steering
	// ------------------------------------------------------------

	// sleep hold keeps the core bus clock on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ahb_clk_keep <= 1'b0;
		end else begin
			ahb_clk_keep <= sleep_mode && ctl_r[SLEEP_BIT];
		end
	end

	// standby with hold runs clocks from internal_rc_osc_clock
	// deep-sleep with hold does the same instead of stopping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_clk_from_rc <= 1'b0;
		end else begin
			sys_clk_from_rc <= (standby_mode && ctl_r[STANDBY_BIT]) ||
				(deepsleep_mode && ctl_r[DSLEEP_BIT]);
		end
	end

	// standby exit gives a one-cycle reset request, hold or not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_d_r <= 1'b0;
			sys_reset_req <= 1'b0;
		end else begin
			standby_d_r <= standby_mode;
			sys_reset_req <= standby_d_r && !standby_mode;
		end
	end

	// ------------------------------------------------------------
	// peripheral freezes
	// ------------------------------------------------------------

	// freeze only while halted and the bit is set
	// registered AND, follows inputs one cycle later
	// freezes gate counting only; held values are never touched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_freeze <= 7'h00;
			smbus_timeout_freeze <= 2'h0;
			window_watchdog_freeze <= 1'b0;
			free_watchdog_freeze <= 1'b0;
			can_rx_freeze <= 2'h0;
		end else begin
			timer_freeze <= {ctl_r[TIMER_HI_BIT+2:TIMER_HI_BIT],
				ctl_r[TIMER_LO_BIT+3:TIMER_LO_BIT]} & {7{core_halted}};
			// smbus timeout of both bus controllers
			smbus_timeout_freeze <= {ctl_r[SMB1_BIT], ctl_r[SMB0_BIT]} &
				{2{core_halted}};
			window_watchdog_freeze <= core_halted && ctl_r[WWDG_BIT];
			free_watchdog_freeze <= core_halted && ctl_r[FWDG_BIT];
			can_rx_freeze <= {ctl_r[CAN1_BIT], ctl_r[CAN0_BIT]} &
				{2{core_halted}};
		end
	end

endmodule

// ---- verif/dbg_hold_checker.sv ----
// assertion checker for the debug hold block
module dbg_hold_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb select
	input wire logic psel,
	// core and power state
	input wire logic core_halted,
	input wire logic sleep_mode,
	input wire logic deepsleep_mode,
	input wire logic standby_mode,
	// watched outputs
	input wire logic ahb_clk_keep,
	input wire logic sys_clk_from_rc,
	input wire logic sys_reset_req,
	input wire logic [6:0] timer_freeze,
	input wire logic [1:0] smbus_timeout_freeze,
	input wire logic window_watchdog_freeze,
	input wire logic free_watchdog_freeze,
	input wire logic [1:0] can_rx_freeze,
	input wire logic [4:0] gpio_release,
	input wire logic scan_data_out_oe
);
	// ----------------------------------------------
	// properties
	// ----------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_timer_hold_run: assert property (
		!core_halted |=> timer_freeze == 7'h00) else $error("timer frozen");
	a_smbus_hold_run: assert property (
		!core_halted |=> smbus_timeout_freeze == 2'h0)
		else $error("timeout frozen");
	a_wdog_hold_run: assert property (
		!core_halted |=> !window_watchdog_freeze && !free_watchdog_freeze)
		else $error("watchdog frozen");
	a_can_hold_run: assert property (
		!core_halted |=> can_rx_freeze == 2'h0) else $error("can frozen");
	// no cause, no change: halted and control both steady
	a_freeze_steady: assert property (
		$stable(core_halted) && !psel && !$past(psel) |=>
		$stable(timer_freeze) && $stable(can_rx_freeze))
		else $error("freeze moved without cause");
	a_sleep_keep: assert property (
		!sleep_mode |=> !ahb_clk_keep) else $error("clock kept awake");
	a_rc_source: assert property (
		!standby_mode && !deepsleep_mode |=> !sys_clk_from_rc)
		else $error("rc source outside low power");
	a_exit_reset: assert property (
		$fell(standby_mode) |-> ##[1:2] sys_reset_req)
		else $error("no reset on standby exit");
	a_reset_cause: assert property (
		sys_reset_req |-> $past(standby_mode, 2) || $past(standby_mode, 3))
		else $error("reset without standby exit");
	a_pin_codes: assert property (
		gpio_release inside {5'h00, 5'h10, 5'h1F})
		else $error("bad pin release pattern");
	a_pins_released: assert property (
		gpio_release == 5'h1F |-> !scan_data_out_oe)
		else $error("data out driven on released pin");
	// main scenarios reached
	c_halt_freeze: cover property (core_halted && timer_freeze != 7'h00);
	c_reset_req: cover property (sys_reset_req);
	c_shift: cover property (scan_data_out_oe);
	c_rc: cover property (sys_clk_from_rc);
endmodule

bind debug_hold_jtag_chain dbg_hold_checker i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel),
	.core_halted(core_halted), .sleep_mode(sleep_mode),
	.deepsleep_mode(deepsleep_mode), .standby_mode(standby_mode),
	.ahb_clk_keep(ahb_clk_keep), .sys_clk_from_rc(sys_clk_from_rc),
	.sys_reset_req(sys_reset_req), .timer_freeze(timer_freeze),
	.smbus_timeout_freeze(smbus_timeout_freeze),
	.window_watchdog_freeze(window_watchdog_freeze),
	.free_watchdog_freeze(free_watchdog_freeze),
	.can_rx_freeze(can_rx_freeze), .gpio_release(gpio_release),
	.scan_data_out_oe(scan_data_out_oe)
);

// ---- verif/scan_probe.sv ----
// behavioural probe driving the five-wire scan port
module scan_probe (
	// bench clock
	input wire logic pclk,
	// probe driven pins
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	// device driven pin
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle: clock stands low between frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b1;
	end
	task automatic step(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge pclk);
		tck <= 1'b1;
		repeat (4) @(posedge pclk);
		// late in high phase, tdo settled since last fall
		q = tdo;
		tck <= 1'b0;
	endtask
	task automatic set_trst(input logic v);
		@(posedge pclk);
		trst_n <= v;
	endtask
	task automatic tap_reset();
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	task automatic shift(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir)
			step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the debug hold and scan chain block
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end
module tb
	import dbg_hold_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic core_halted = 1'b0, sleep_mode = 1'b0;
	logic deepsleep_mode = 1'b0, standby_mode = 1'b0;
	logic [31:0] prdata, rd, ctl_m, rnd;
	logic pready, pslverr, er, tck, tms, tdi, trst_n, tdo, oe;
	logic ahb_clk_keep, sys_clk_from_rc, sys_reset_req, wwf, fwf;
	logic [4:0] gpio_release;
	logic [6:0] timer_freeze;
	logic [1:0] smb, can;
	logic [63:0] sout;
	logic [7:0] exp8;
	logic [6:0] exp7;
	logic bq[$];
	int errors = 0, cmp_count = 0, seed = 32'h3149_8cb6;
	// 40 MHz bench clock
	always #12.5 pclk = ~pclk;
	debug_hold_jtag_chain i_debug_hold_jtag_chain (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scan_clock_pin(tck), .scan_mode_select_pin(tms),
		.scan_data_in_pin(tdi), .scan_reset_n_pin(trst_n),
		.scan_data_out_pin(tdo), .scan_data_out_oe(oe),
		.gpio_release(gpio_release), .core_halted(core_halted),
		.sleep_mode(sleep_mode), .deepsleep_mode(deepsleep_mode),
		.standby_mode(standby_mode), .ahb_clk_keep(ahb_clk_keep),
		.sys_clk_from_rc(sys_clk_from_rc), .sys_reset_req(sys_reset_req),
		.timer_freeze(timer_freeze), .smbus_timeout_freeze(smb),
		.window_watchdog_freeze(wwf), .free_watchdog_freeze(fwf),
		.can_rx_freeze(can));
	// data out line has a pull-up: undriven, the probe reads ones
	scan_probe probe (.pclk(pclk), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .tdo(oe ? tdo : 1'b1));
	// ----------------------------------------------
	// tasks
	// ----------------------------------------------
	task automatic test_done();
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one apb transfer, answer taken at the edge where pready is high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			errors++;
			$display("CHECK FAILED at %0t: no pready", $time);
			test_done();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pins(input logic [1:0] m);
		apb(1'b1, PINCFG_ADDR, {30'h0, m}, rd, er);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask
	// ----------------------------------------------
	// main sequence
	// ----------------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK(gpio_release, 5'h00)
		apb(1'b0, ID_ADDR, ZERO_WORD, rd, er);
		`CHK(rd, APB_ID_VALUE)
		apb(1'b0, CTL_ADDR, ZERO_WORD, rd, er);
		`CHK(rd, CTL_RESET)
		apb(1'b0, PINCFG_ADDR, ZERO_WORD, rd, er);
		`CHK(rd[1:0], PINCFG_RESET)
		apb(1'b1, ID_ADDR, ZERO_WORD, rd, er);
		apb(1'b0, ID_ADDR, ZERO_WORD, rd, er);
		`CHK(rd, APB_ID_VALUE)
		apb(1'b0, 12'h010, ZERO_WORD, rd, er);
		`CHK({er, rd}, {1'b1, ZERO_WORD})
		// random holds against halted and power modes
		for (int k = 0; k < 24; k++) begin
			ctl_m = $random(seed);
			apb(1'b1, CTL_ADDR, ctl_m, rd, er);
			ctl_m = ctl_m & CTL_WMASK;
			rnd = $random(seed);
			core_halted <= k[0];
			sleep_mode <= rnd[SLEEP_BIT];
			deepsleep_mode <= rnd[DSLEEP_BIT];
			standby_mode <= rnd[STANDBY_BIT];
			repeat (2) @(posedge pclk);
			@(negedge pclk);
			`CHK(ahb_clk_keep, rnd[0] & ctl_m[SLEEP_BIT])
			`CHK(sys_clk_from_rc, |(rnd[2:1] & ctl_m[2:1]))
			exp7 = {ctl_m[TIMER_HI_BIT+:3], ctl_m[TIMER_LO_BIT+:4]};
			`CHK(timer_freeze, exp7 & {7{k[0]}})
			`CHK(smb, {ctl_m[SMB1_BIT], ctl_m[SMB0_BIT]} & {2{k[0]}})
			`CHK({wwf, fwf}, ctl_m[9:8] & {2{k[0]}})
			`CHK(can, {ctl_m[CAN1_BIT], ctl_m[CAN0_BIT]} & {2{k[0]}})
			apb(1'b0, CTL_ADDR, ZERO_WORD, rd, er);
			`CHK(rd, ctl_m)
		end
		// standby exit: one reset request pulse, one cycle wide
		standby_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		standby_mode <= 1'b0;
		@(negedge pclk);
		`CHK(sys_reset_req, 1'b0)
		@(negedge pclk);
		`CHK(sys_reset_req, 1'b1)
		@(negedge pclk);
		`CHK(sys_reset_req, 1'b0)
		repeat (3) @(posedge pclk);
		apb(1'b0, CTL_ADDR, ZERO_WORD, rd, er);
		`CHK(rd, ctl_m)
		// chained data register: boundary id nearest data out
		probe.tap_reset();
		probe.shift(1'b0, 64, 64'h0, sout);
		`CHK(sout, {CORE_ID_VALUE, BSCAN_ID_VALUE})
		probe.shift(1'b1, 10, 64'h0000_0000_0000_03FF, sout);
		`CHK(sout[9:0], 10'h021)
		// both in bypass: two-stage delay queue
		rnd = $random(seed);
		bq = {1'b0, 1'b0};
		for (int i = 0; i < 8; i++) begin
			bq.push_back(rnd[i]);
			exp8[i] = bq.pop_front();
		end
		probe.shift(1'b0, 8, {56'h0, rnd[7:0]}, sout);
		`CHK(sout[7:0], exp8)
		pins(PIN_NO_RESET);
		`CHK(gpio_release, 5'h10)
		probe.set_trst(1'b0);
		probe.tap_reset();
		probe.shift(1'b0, 32, 64'h0, sout);
		`CHK(sout[31:0], BSCAN_ID_VALUE)
		apb(1'b0, STATUS_ADDR, ZERO_WORD, rd, er);
		`CHK(rd[8], 1'b1)
		pins(PIN_RELEASED);
		`CHK(gpio_release, 5'h1F)
		probe.shift(1'b0, 8, 64'h0, sout);
		`CHK(sout[7:0], 8'hFF)
		`CHK(oe, 1'b0)
		pins(PIN_FULL);
		`CHK(gpio_release, 5'h00)
		probe.set_trst(1'b1);
		probe.tap_reset();
		apb(1'b0, STATUS_ADDR, ZERO_WORD, rd, er);
		`CHK(rd[3:0], TAP_IDLE)
		probe.set_trst(1'b0);
		repeat (8) @(posedge pclk);
		apb(1'b0, STATUS_ADDR, ZERO_WORD, rd, er);
		`CHK(rd[3:0], TAP_RESET)
		apb(1'b0, CTL_ADDR, ZERO_WORD, rd, er);
		`CHK(rd, ctl_m)
		test_done();
	end
endmodule
